// ===== rtl/ckhr_pkg.sv
// constants and state types for the crypto key host registers
package ckhr_pkg;

    // apb geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int KEY_W  = 128;
    localparam int WORD_N = 4;

    // register byte offsets
    localparam logic [15:0] OFF_KEY_SEL = 16'h1a38;
    localparam logic [15:0] OFF_LOCK    = 16'h1a4c;
    localparam logic [15:0] OFF_ROOT0   = 16'h1a50;
    localparam logic [15:0] OFF_ROOT1   = 16'h1a54;
    localparam logic [15:0] OFF_ROOT2   = 16'h1a58;
    localparam logic [15:0] OFF_ROOT3   = 16'h1a5c;
    localparam logic [15:0] OFF_LCS     = 16'h1a60;

    // field layout
    localparam int SEL_W     = 2;
    localparam int LOCK_BIT  = 0;
    localparam int LCS_W     = 3;
    localparam int LCS_V_BIT = 8;
    localparam int ROOT_V_BIT = 0;

    // key source encodings
    typedef enum logic [1:0] {
        SRC_ROOT    = 2'b00,
        SRC_RTL     = 2'b01,
        SRC_SESSION = 2'b10,
        SRC_NONE    = 2'b11
    } ckhr_src_e;

    // lifecycle encodings
    localparam logic [2:0] LCS_DEBUG  = 3'h0;
    localparam logic [2:0] LCS_SECURE = 3'h2;

    // reset values
    localparam logic [1:0]  SEL_RST  = 2'h0;
    localparam logic        LOCK_RST = 1'b0;
    localparam logic [2:0]  LCS_RST  = LCS_SECURE;
    localparam logic [31:0] ZERO_W   = 32'h0000_0000;

    // always-on state: cleared by power-on reset only
    typedef struct packed {
        logic [KEY_W-1:0]  root_key;
        logic [WORD_N-1:0] root_seen;
        logic              lock;
    } ckhr_ao_s;

    // main-domain state: cleared by system reset
    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic [LCS_W-1:0]  lifecycle_state;
        logic              lcs_valid;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        logic [KEY_W-1:0]  aes_key;
    } ckhr_main_s;

endpackage : ckhr_pkg

// ===== rtl/ckhr_regs.sv
// host register bank choosing the aes hardware key
//
// Contract
// - select 0 routes the always-on device root key to aes.
// - select 1 routes the hardcoded rtl key while unlocked.
// - select 2 routes the external session key to aes.
// - select 1 with lock set drives an all-zero key.
// - rtl key lock is write-once; writes never clear it.
// - lock and root key words live in always-on storage.
// - root key word0 write loads key bits 31:0.
// - words 1,2,3 load key bits 63:32, 95:64, 127:96.
// - reading word0 returns retention status, never key bits.
// - lock is bit 0, resets to zero; clear lets rtl key be chosen.
// - status reads 1 once all 128 bits retained, else 0.
// - lifecycle field write-once per reset; 0 debug, 2 secure.
`timescale 1ns/1ps
`default_nettype none

module ckhr_regs #(
    parameter logic [127:0] HARDCODED_RTL_KEY = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
    // clock and resets
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         PWR_ON_RST,
    // apb slave
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [15:0]  PADDR,
    input  wire logic [31:0]  PWDATA,
    output var  logic         PREADY,
    output var  logic [31:0]  PRDATA,
    output var  logic         PSLVERR,
    // key path
    input  wire logic [127:0] SESSION_KEY,
    output var  logic [127:0] AES_HW_KEY,
    // status
    output var  logic         RTL_KEY_LOCKED,
    output var  logic         ROOT_KEY_VALID,
    output var  logic [2:0]   LIFECYCLE_STATE,
    output var  logic         LIFECYCLE_VALID
);

    ckhr_pkg::ckhr_ao_s   ao_q;
    ckhr_pkg::ckhr_ao_s   ao_d;
    ckhr_pkg::ckhr_main_s st_q;
    ckhr_pkg::ckhr_main_s st_d;

    logic setup;
    logic wr_now;
    logic hit;

    // true when the address names a mapped register
    function automatic logic mapped(input logic [15:0] a);
        mapped = (a == ckhr_pkg::OFF_KEY_SEL) || (a == ckhr_pkg::OFF_LOCK) ||
                 (a == ckhr_pkg::OFF_ROOT0)   || (a == ckhr_pkg::OFF_ROOT1) ||
                 (a == ckhr_pkg::OFF_ROOT2)   || (a == ckhr_pkg::OFF_ROOT3) ||
                 (a == ckhr_pkg::OFF_LCS);
    endfunction : mapped

    // root key word index for a root key offset
    function automatic logic [1:0] word_of(input logic [15:0] a);
        word_of = a[3:2];
    endfunction : word_of

    // key presented to aes for a given source and lock
    function automatic logic [127:0] pick_key(
        input logic [1:0]   sel,
        input logic         lock,
        input logic [127:0] root,
        input logic [127:0] sess
    );
        unique case (ckhr_pkg::ckhr_src_e'(sel))
            ckhr_pkg::SRC_ROOT:    pick_key = root;
            ckhr_pkg::SRC_RTL:     pick_key = lock ? '0 : HARDCODED_RTL_KEY;
            ckhr_pkg::SRC_SESSION: pick_key = sess;
            ckhr_pkg::SRC_NONE:    pick_key = '0;
        endcase
    endfunction : pick_key

    // the answer is prepared in the setup cycle, so every access has no wait state
    assign setup  = PSEL && !PENABLE;
    assign wr_now = PSEL && PENABLE && st_q.pready && PWRITE;
    assign hit    = mapped(PADDR);

    // always-on next state
    always_comb begin
        ao_d = ao_q;
        if (wr_now && hit) begin
            if (PADDR == ckhr_pkg::OFF_LOCK && PWDATA[ckhr_pkg::LOCK_BIT]) begin
                ao_d.lock = 1'b1;
            end
            if (PADDR >= ckhr_pkg::OFF_ROOT0 && PADDR <= ckhr_pkg::OFF_ROOT3) begin
                unique case (word_of(PADDR))
                    2'h0: ao_d.root_key[31:0]   = PWDATA;
                    2'h1: ao_d.root_key[63:32]  = PWDATA;
                    2'h2: ao_d.root_key[95:64]  = PWDATA;
                    2'h3: ao_d.root_key[127:96] = PWDATA;
                endcase
                ao_d.root_seen[word_of(PADDR)] = 1'b1;
            end
        end
    end

    // main-domain next state
    always_comb begin
        st_d         = st_q;
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        if (setup) begin
            st_d.pslverr = !hit;
            st_d.prdata  = ckhr_pkg::ZERO_W;
            if (!PWRITE) begin
                unique case (PADDR)
                    ckhr_pkg::OFF_KEY_SEL: st_d.prdata[ckhr_pkg::SEL_W-1:0] = st_q.sel;
                    ckhr_pkg::OFF_LOCK:    st_d.prdata[ckhr_pkg::LOCK_BIT] = ao_q.lock;
                    ckhr_pkg::OFF_ROOT0:   st_d.prdata[ckhr_pkg::ROOT_V_BIT] =
                                               &ao_q.root_seen;
                    ckhr_pkg::OFF_LCS: begin
                        st_d.prdata[ckhr_pkg::LCS_W-1:0]  = st_q.lifecycle_state;
                        st_d.prdata[ckhr_pkg::LCS_V_BIT] = st_q.lcs_valid;
                    end
                    default:               st_d.prdata = ckhr_pkg::ZERO_W;
                endcase
            end
        end
        if (wr_now && PADDR == ckhr_pkg::OFF_KEY_SEL) begin
            st_d.sel = PWDATA[ckhr_pkg::SEL_W-1:0];
        end
        // a second lifecycle write in the same reset period is dropped
        if (wr_now && PADDR == ckhr_pkg::OFF_LCS && !st_q.lcs_valid) begin
            st_d.lifecycle_state       = PWDATA[ckhr_pkg::LCS_W-1:0];
            st_d.lcs_valid = 1'b1;
        end
        st_d.aes_key = pick_key(st_q.sel, ao_q.lock, ao_q.root_key, SESSION_KEY);
    end

    // retained storage: system reset does not touch it
    always_ff @(posedge CLK or posedge PWR_ON_RST) begin
        if (PWR_ON_RST) begin
            ao_q.root_key  <= '0;
            ao_q.root_seen <= '0;
            ao_q.lock      <= ckhr_pkg::LOCK_RST;
        end else begin
            ao_q <= ao_d;
        end
    end

    // system-reset state
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q.sel       <= ckhr_pkg::SEL_RST;
            st_q.lifecycle_state       <= ckhr_pkg::LCS_RST;
            st_q.lcs_valid <= 1'b0;
            st_q.pready    <= 1'b0;
            st_q.pslverr   <= 1'b0;
            st_q.prdata    <= '0;
            st_q.aes_key   <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign PREADY          = st_q.pready;
    assign PRDATA          = st_q.prdata;
    assign PSLVERR         = st_q.pslverr;
    assign AES_HW_KEY      = st_q.aes_key;
    assign RTL_KEY_LOCKED  = ao_q.lock;
    assign ROOT_KEY_VALID  = &ao_q.root_seen;
    assign LIFECYCLE_STATE = st_q.lifecycle_state;
    assign LIFECYCLE_VALID = st_q.lcs_valid;

endmodule : ckhr_regs

`default_nettype wire

// ===== sim/ckhr_regs_asserts.sv
// port assertions for the crypto key host registers
`timescale 1ns/1ps
`default_nettype none
module ckhr_regs_asserts #(
    parameter logic [127:0] RTL_K = '0
) (
    input wire logic CLK, SYS_RST, PWR_ON_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
    input wire logic         RTL_KEY_LOCKED, ROOT_KEY_VALID, LIFECYCLE_VALID,
    input wire logic [2:0]   LIFECYCLE_STATE,
    input wire logic [15:0]  PADDR,
    input wire logic [31:0]  PWDATA, PRDATA,
    input wire logic [127:0] SESSION_KEY, AES_HW_KEY
);
    // select is not a port, so it is rebuilt from completed bus writes
    logic [1:0] sel_q;
    wire logic  setup  = PSEL && !PENABLE;
    wire logic  wr_end = PSEL && PENABLE && PREADY && PWRITE;
    wire logic  mapped = PADDR == ckhr_pkg::OFF_KEY_SEL ||
        (PADDR[1:0] == 2'h0 && PADDR inside {[ckhr_pkg::OFF_LOCK:ckhr_pkg::OFF_LCS]});
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) sel_q <= 2'h0;
        else if (wr_end && PADDR == ckhr_pkg::OFF_KEY_SEL) sel_q <= PWDATA[1:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST || PWR_ON_RST);
    ready_once_a: assert property (setup |=> PREADY ##1 !PREADY) else $error("ready pulse");
    unmapped_err_a: assert property (setup && !mapped |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access");
    status_read_a: assert property (setup && !PWRITE && PADDR == ckhr_pkg::OFF_ROOT0
        |=> PRDATA == {31'h0, ROOT_KEY_VALID}) else $error("root status read");
    lock_kept_a: assert property (RTL_KEY_LOCKED |=> RTL_KEY_LOCKED) else $error("lock lost");
    lock_set_a: assert property (wr_end && PADDR == ckhr_pkg::OFF_LOCK && PWDATA[0]
        |=> RTL_KEY_LOCKED) else $error("lock not set");
    rtl_key_a: assert property (sel_q == 2'h1 && !RTL_KEY_LOCKED |=> AES_HW_KEY == RTL_K)
        else $error("rtl key");
    zero_key_a: assert property (sel_q == 2'h1 && RTL_KEY_LOCKED |=> AES_HW_KEY == '0)
        else $error("zero key");
    session_key_a: assert property (sel_q == 2'h2 |=> AES_HW_KEY == $past(SESSION_KEY))
        else $error("session key");
    lcs_once_a: assert property (LIFECYCLE_VALID |=> LIFECYCLE_VALID && $stable(LIFECYCLE_STATE))
        else $error("lifecycle rewritten");
endmodule : ckhr_regs_asserts
bind ckhr_regs ckhr_regs_asserts #(.RTL_K(HARDCODED_RTL_KEY)) asserts_u (.CLK(CLK),
    .SYS_RST(SYS_RST), .PWR_ON_RST(PWR_ON_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .RTL_KEY_LOCKED(RTL_KEY_LOCKED),
    .ROOT_KEY_VALID(ROOT_KEY_VALID), .LIFECYCLE_VALID(LIFECYCLE_VALID), .PADDR(PADDR),
    .LIFECYCLE_STATE(LIFECYCLE_STATE), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .SESSION_KEY(SESSION_KEY), .AES_HW_KEY(AES_HW_KEY));
`default_nettype wire

// ===== sim/ckhr_regs_test.sv
// self-checking bench for the crypto key host registers
`timescale 1ns/1ps
`default_nettype none
module ckhr_regs_test;
    localparam logic [127:0] RTL_K  = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0; // arbitrary
    localparam logic [127:0] ROOT_K = 128'h4433_2211_8877_6655_ccbb_aa99_00ff_eedd;
    typedef struct packed {logic w; logic [15:0] a; logic [31:0] d, r; logic e;} ckhr_row_s;
    logic CLK, SYS_RST, PWR_ON_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
    logic         RTL_KEY_LOCKED, ROOT_KEY_VALID, LIFECYCLE_VALID;
    logic [2:0]   LIFECYCLE_STATE;
    logic [15:0]  PADDR;
    logic [31:0]  PWDATA, PRDATA, rd;
    logic [127:0] SESSION_KEY, AES_HW_KEY;
    int           err_total = 0, checks = 0;
    ckhr_row_s rows [14] = '{
        '{1'b0, ckhr_pkg::OFF_KEY_SEL, '0, '0, 1'b0}, '{1'b0, ckhr_pkg::OFF_LOCK, '0, '0, 1'b0},
        '{1'b0, ckhr_pkg::OFF_ROOT0, '0, '0, 1'b0}, '{1'b0, ckhr_pkg::OFF_LCS, '0, 32'h2, 1'b0},
        '{1'b1, ckhr_pkg::OFF_ROOT0, ROOT_K[31:0], '0, 1'b0},
        '{1'b1, ckhr_pkg::OFF_ROOT1, ROOT_K[63:32], '0, 1'b0},
        '{1'b1, ckhr_pkg::OFF_ROOT2, ROOT_K[95:64], '0, 1'b0},
        '{1'b1, ckhr_pkg::OFF_ROOT3, ROOT_K[127:96], '0, 1'b0},
        '{1'b0, ckhr_pkg::OFF_ROOT0, '0, 32'h1, 1'b0}, '{1'b1, ckhr_pkg::OFF_LCS, '0, '0, 1'b0},
        '{1'b0, ckhr_pkg::OFF_LCS, '0, 32'h100, 1'b0}, '{1'b1, ckhr_pkg::OFF_LCS, 32'h2, '0, 1'b0},
        '{1'b0, ckhr_pkg::OFF_LCS, '0, 32'h100, 1'b0}, '{1'b1, 16'h1a3c, 32'h1, '0, 1'b1}};
    ckhr_regs #(.HARDCODED_RTL_KEY(RTL_K)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
        .PWR_ON_RST(PWR_ON_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .SESSION_KEY(SESSION_KEY), .AES_HW_KEY(AES_HW_KEY), .RTL_KEY_LOCKED(RTL_KEY_LOCKED),
        .ROOT_KEY_VALID(ROOT_KEY_VALID), .LIFECYCLE_STATE(LIFECYCLE_STATE),
        .LIFECYCLE_VALID(LIFECYCLE_VALID));
    ckhr_sess_model sess_u (.clk(CLK), .session_key(SESSION_KEY));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [127:0] s, input logic [127:0] x);
        checks++;
        if (s !== x) begin
            err_total++;
            $display("unexpected at %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // setup, then access held until ready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        e = PSLVERR;
        if (PREADY !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    task automatic pulse_settle(input logic sys);
        @(posedge CLK);
        {SYS_RST, PWR_ON_RST} <= {sys, !sys};
        @(posedge CLK);
        {SYS_RST, PWR_ON_RST} <= 2'b00;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
    endtask : pulse_settle
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, SYS_RST, PWR_ON_RST} = {51'h0, 2'b11};
        repeat (3) @(posedge CLK);
        {SYS_RST, PWR_ON_RST} <= 2'b00;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({rows[i].w ? 32'h0 : rd, e}, {rows[i].r, rows[i].e});
        end
        chk({LIFECYCLE_VALID, LIFECYCLE_STATE}, {1'b1, ckhr_pkg::LCS_DEBUG});
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, ckhr_pkg::OFF_KEY_SEL, 32'(s));
            repeat (2) @(negedge CLK);
            // the session source shifts each cycle, so undo one step to get the sampled key
            chk(AES_HW_KEY, s == 0 ? ROOT_K : s == 1 ? RTL_K :
                {~SESSION_KEY[0], SESSION_KEY[127:1]});
        end
        apb(1'b1, ckhr_pkg::OFF_LOCK, 32'h1);
        apb(1'b1, ckhr_pkg::OFF_KEY_SEL, 32'h1);
        repeat (2) @(negedge CLK);
        chk(AES_HW_KEY, '0);
        apb(1'b1, ckhr_pkg::OFF_LOCK, 32'h0);
        apb(1'b0, ckhr_pkg::OFF_LOCK, 32'h0);
        chk(rd, 32'h1);
        pulse_settle(1'b1);
        chk(AES_HW_KEY, ROOT_K);
        chk({RTL_KEY_LOCKED, ROOT_KEY_VALID}, 2'b11);
        chk({LIFECYCLE_VALID, LIFECYCLE_STATE}, {1'b0, ckhr_pkg::LCS_SECURE});
        pulse_settle(1'b0);
        chk({RTL_KEY_LOCKED, ROOT_KEY_VALID}, 2'b00);
        report_and_stop();
    end
endmodule : ckhr_regs_test
`default_nettype wire

// ===== sim/ckhr_sess_model.sv
// session key source on the far side of the aes key path
`timescale 1ns/1ps
`default_nettype none
module ckhr_sess_model (
    input  wire logic         clk,
    output var  logic [127:0] session_key
);
    // changes every cycle so a stale sample of the key never passes
    initial session_key = 128'h5a5a_0000_c3c3_0000_a5a5_0000_3c3c_0001;
    // plain always: the initial value above is a second writer, which always_ff forbids
    always @(posedge clk) begin
        session_key <= {session_key[126:0], ~session_key[127]};
    end
endmodule : ckhr_sess_model
`default_nettype wire
